// ### rtl/pfc_pkg.sv
package pfc_pkg;
  // bus pin widths, toggle bit and clock rate
  localparam int unsigned ADDR_W          = 17;
  localparam int unsigned DATA_W          = 8;
  localparam int unsigned CMD_ADDR_W      = 15;
  localparam int unsigned TOGGLE_BIT      = 6;
  localparam int unsigned CLK_MHZ         = 125;
  // pin timing in ns, counts rounded up
  localparam int unsigned T_WP_NS         = 90;
  localparam int unsigned T_WPH_NS        = 90;
  localparam int unsigned T_ACC_NS        = 120;
  localparam int unsigned T_OEHP_NS       = 150;
  localparam int unsigned CLK_NS          = 1000 / CLK_MHZ;
  localparam int unsigned WP_CYC          = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WPH_CYC         = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned ACC_CYC         = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned OEHP_CYC        = (T_OEHP_NS + CLK_NS - 1) / CLK_NS;
  // operation limits
  localparam int unsigned T_BP_MAX_US     = 50;
  localparam int unsigned T_EC_MAX_S      = 10;
  localparam longint unsigned BP_CYC      = 64'(T_BP_MAX_US) * CLK_MHZ;
  localparam longint unsigned EC_CYC      = 64'(T_EC_MAX_S) * 1000000 * CLK_MHZ;
  localparam int unsigned TMO_W           = 32;
  localparam int unsigned PHASE_W         = 8;
  // boot block range, lower placement
  localparam logic [16:0] BOOT_LO         = 17'h00000;
  localparam logic [16:0] BOOT_HI         = 17'h01fff;
  localparam logic [16:0] ID_MFR_ADDR     = 17'h00000;
  localparam logic [16:0] ID_DEV_ADDR     = 17'h00001;
  // host operations
  typedef enum logic [2:0] {
    PFC_OP_READ,
    PFC_OP_PROGRAM,
    PFC_OP_ERASE,
    PFC_OP_ID_ENTER,
    PFC_OP_ID_EXIT,
    PFC_OP_LOCKOUT,
    PFC_OP_RAW
  } pfc_op_t;
  // cycle kinds for the pin sequencer
  typedef enum logic [1:0] {
    PFC_CYC_WRITE,
    PFC_CYC_READ,
    PFC_CYC_ERASE_WRITE
  } pfc_cyc_t;
endpackage : pfc_pkg

// ### rtl/pfc_bus_cycle.sv
module pfc_bus_cycle
  import pfc_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire logic              start,
  input  wire pfc_cyc_t          kind,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [DATA_W-1:0] dq_i,
  output logic                   busy,
  output logic                   done,
  output logic [DATA_W-1:0]      rdata,
  output logic [ADDR_W-1:0]      addr_o,
  output logic [DATA_W-1:0]      dq_o,
  output logic                   dq_oe,
  output logic                   ce_n,
  output logic                   oe_n,
  output logic                   we_n
);
  typedef enum logic [1:0] {S_IDLE, S_STROBE, S_RECOVER} pfc_bc_state_t;

  pfc_bc_state_t        st_q;
  logic [PHASE_W-1:0]   cnt_q;
  pfc_cyc_t             kind_q;
  logic                 done_q;

  wire logic is_read  = (kind_q == PFC_CYC_READ);
  wire logic is_erase = (kind_q == PFC_CYC_ERASE_WRITE);
  wire logic [PHASE_W-1:0] strobe_len = is_read ? PHASE_W'(ACC_CYC) : PHASE_W'(WP_CYC);
  wire logic [PHASE_W-1:0] rec_len    = is_read ? PHASE_W'(OEHP_CYC) : PHASE_W'(WPH_CYC);
  wire logic cnt_end = (cnt_q == '0);

  assign busy = (st_q != S_IDLE);
  assign done = done_q;

  always_ff @(posedge sys_clk) begin
    done_q <= 1'b0;
    if (srst) begin
      st_q   <= S_IDLE;
      cnt_q  <= '0;
      kind_q <= PFC_CYC_READ;
      addr_o <= '0;
      dq_o   <= '0;
      dq_oe  <= 1'b0;
      ce_n   <= 1'b1;
      oe_n   <= 1'b1;
      we_n   <= 1'b1;
      rdata  <= '0;
    end else begin
      unique case (st_q)
        S_IDLE: begin
          if (start) begin
            kind_q <= kind;
            addr_o <= addr;
            dq_o   <= wdata;
            dq_oe  <= (kind != PFC_CYC_READ);
            ce_n   <= 1'b0;
            we_n   <= (kind == PFC_CYC_READ);
            // erase writes raise oe only under both strobes low
            oe_n   <= (kind != PFC_CYC_READ);
            cnt_q  <= (kind == PFC_CYC_READ) ? PHASE_W'(ACC_CYC - 1) : PHASE_W'(WP_CYC - 1);
            st_q   <= S_STROBE;
          end
        end
        S_STROBE: begin
          if (cnt_end) begin
            // read samples at end of access; oe/ce release gives the poll edge
            if (is_read) rdata <= dq_i;
            ce_n  <= 1'b1;
            we_n  <= 1'b1;
            oe_n  <= 1'b1;
            if (is_erase) oe_n <= 1'b0;
            cnt_q <= rec_len - 1'b1;
            st_q  <= S_RECOVER;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        S_RECOVER: begin
          // erase keeps oe low between its strobes
          if (!is_erase) oe_n <= 1'b1;
          if (cnt_end) begin
            dq_oe  <= 1'b0;
            done_q <= 1'b1;
            st_q   <= S_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
  wire logic unused_len = |strobe_len;
endmodule : pfc_bus_cycle

// ### rtl/pfc_host.sv
module pfc_host
  import pfc_pkg::*;
#(
  parameter longint unsigned BP_TMO = BP_CYC,
  parameter longint unsigned EC_TMO = EC_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire logic              req_valid,
  input  wire pfc_op_t           req_op,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_data,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_data,
  output logic                   rsp_timeout,
  output logic                   id_mode,
  output logic                   boot_hit,
  output logic [ADDR_W-1:0]      flash_addr,
  input  wire logic [DATA_W-1:0] flash_dq_i,
  output logic [DATA_W-1:0]      flash_dq_o,
  output logic                   flash_dq_oe,
  output logic                   flash_ce_n,
  output logic                   flash_oe_n,
  output logic                   flash_we_n
);
  typedef enum logic [2:0] {
    H_IDLE, H_ISSUE, H_WAIT, H_POLL, H_POLL_WAIT, H_DONE
  } pfc_h_state_t;

  pfc_h_state_t       st_q;
  pfc_op_t            op_q;
  logic [ADDR_W-1:0]  addr_q;
  logic [DATA_W-1:0]  data_q;
  logic [2:0]         step_q;
  logic [TMO_W-1:0]   tmo_q;
  logic               have_prev_q;
  logic               prev_tog_q;
  logic               timeout_q;
  logic               valid_q;
  logic [DATA_W-1:0]  rsp_q;
  logic               id_q;

  logic               bc_start;
  pfc_cyc_t           bc_kind;
  logic [ADDR_W-1:0]  bc_addr;
  logic [DATA_W-1:0]  bc_wdata;
  logic               bc_busy;
  logic               bc_done;
  logic [DATA_W-1:0]  bc_rdata;

  // command unlock word: address on low fifteen bits, hex data byte
  function automatic logic [ADDR_W+DATA_W-1:0] cmd_word(input logic [CMD_ADDR_W-1:0] a,
                                                        input logic [DATA_W-1:0] d);
    cmd_word = {2'b00, a, d};
  endfunction : cmd_word

  // op tail byte, sequence parameters are plain defaults
  function automatic logic [ADDR_W+DATA_W-1:0] seq_word(input pfc_op_t op,
                                                        input logic [2:0] step);
    logic [DATA_W-1:0] tail;
    tail = 8'hf0;
    unique case (op)
      PFC_OP_PROGRAM:  tail = 8'ha0;
      PFC_OP_ERASE:    tail = (step < 3'd3) ? 8'h80 : 8'h10;
      PFC_OP_ID_ENTER: tail = 8'h90;
      PFC_OP_ID_EXIT:  tail = 8'hf0;
      PFC_OP_LOCKOUT:  tail = (step < 3'd3) ? 8'h80 : 8'h40;
      default:         tail = 8'hf0;
    endcase
    // six-word ops repeat the unlock pair before their tail
    if (step == 3'd0 || step == 3'd3)
      seq_word = cmd_word(15'h5555, 8'haa);
    else if (step == 3'd1 || step == 3'd4)
      seq_word = cmd_word(15'h2aaa, 8'h55);
    else
      seq_word = cmd_word(15'h5555, tail);
  endfunction : seq_word

  wire logic [2:0] unlock_len = (op_q == PFC_OP_ERASE || op_q == PFC_OP_LOCKOUT)
                                ? 3'd6 : 3'd3;
  wire logic [ADDR_W+DATA_W-1:0] cur_word = seq_word(op_q, step_q);
  wire logic is_raw_phase  = (step_q == unlock_len);
  wire logic needs_poll    = (op_q == PFC_OP_PROGRAM || op_q == PFC_OP_ERASE);
  wire logic tog_now       = bc_rdata[TOGGLE_BIT];
  // erase limit needs 31 of the 32 bits at this clock
  wire logic [TMO_W-1:0] tmo_lim = (op_q == PFC_OP_ERASE) ? TMO_W'(EC_TMO) : TMO_W'(BP_TMO);

  // boot range flag for the host's own address
  assign boot_hit  = (req_addr >= BOOT_LO) && (req_addr <= BOOT_HI);
  assign req_ready = (st_q == H_IDLE);
  assign rsp_valid   = valid_q;
  assign rsp_data    = rsp_q;
  assign rsp_timeout = timeout_q;
  assign id_mode     = id_q;

  assign bc_start = (st_q == H_ISSUE) || (st_q == H_POLL);
  assign bc_kind  = (st_q == H_POLL || op_q == PFC_OP_READ) ? PFC_CYC_READ :
                    (op_q == PFC_OP_ERASE) ? PFC_CYC_ERASE_WRITE : PFC_CYC_WRITE;
  // one unchanged address for every poll read
  assign bc_addr  = (st_q == H_POLL || op_q == PFC_OP_READ ||
                     op_q == PFC_OP_RAW || (op_q == PFC_OP_PROGRAM && is_raw_phase))
                    ? addr_q : cur_word[ADDR_W+DATA_W-1:DATA_W];
  assign bc_wdata = (op_q == PFC_OP_RAW || (op_q == PFC_OP_PROGRAM && is_raw_phase))
                    ? data_q : cur_word[DATA_W-1:0];

  always_ff @(posedge sys_clk) begin
    valid_q <= 1'b0;
    if (srst) begin
      st_q        <= H_IDLE;
      op_q        <= PFC_OP_READ;
      addr_q      <= '0;
      data_q      <= '0;
      step_q      <= '0;
      tmo_q       <= '0;
      have_prev_q <= 1'b0;
      prev_tog_q  <= 1'b0;
      timeout_q   <= 1'b0;
      rsp_q       <= '0;
      id_q        <= 1'b0;
    end else begin
      unique case (st_q)
        H_IDLE: begin
          if (req_valid) begin
            op_q      <= req_op;
            addr_q    <= req_addr;
            data_q    <= req_data;
            step_q    <= '0;
            timeout_q <= 1'b0;
            st_q      <= H_ISSUE;
          end
        end
        H_ISSUE: st_q <= H_WAIT;
        H_WAIT: begin
          if (bc_done) begin
            if (op_q == PFC_OP_READ || op_q == PFC_OP_RAW ||
                (op_q != PFC_OP_PROGRAM && step_q == unlock_len - 1'b1) ||
                (op_q == PFC_OP_PROGRAM && is_raw_phase)) begin
              rsp_q <= bc_rdata;
              if (needs_poll) begin
                tmo_q       <= '0;
                have_prev_q <= 1'b0;
                st_q        <= H_POLL;
              end else begin
                st_q <= H_DONE;
              end
              // id codes are read at address_bit_zero 0/1 via plain reads
              if (op_q == PFC_OP_ID_ENTER) id_q <= 1'b1;
              if (op_q == PFC_OP_ID_EXIT)  id_q <= 1'b0;
            end else begin
              step_q <= step_q + 1'b1;
              st_q   <= H_ISSUE;
            end
          end
        end
        H_POLL: begin
          // launch cycles count too, so the limit tracks elapsed time
          if (tmo_q != '1) tmo_q <= tmo_q + 1'b1;
          st_q <= H_POLL_WAIT;
        end
        H_POLL_WAIT: begin
          if (tmo_q != '1) tmo_q <= tmo_q + 1'b1;
          if (bc_done) begin
            prev_tog_q  <= tog_now;
            have_prev_q <= 1'b1;
            rsp_q       <= bc_rdata;
            // level is meaningless; an unchanged pair or reaching the limit ends the wait
            if (have_prev_q && (tog_now == prev_tog_q)) begin
              st_q <= H_DONE;
            end else if (tmo_q >= tmo_lim) begin
              timeout_q <= 1'b1;
              st_q      <= H_DONE;
            end else begin
              st_q <= H_POLL;
            end
          end
        end
        H_DONE: begin
          valid_q <= 1'b1;
          st_q    <= H_IDLE;
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // lockout needs no poll: the device latches it at sequence end
  wire logic unused_lock = (op_q == PFC_OP_LOCKOUT);

  pfc_bus_cycle u_cycle (
    .sys_clk (sys_clk),
    .srst    (srst),
    .start   (bc_start),
    .kind    (bc_kind),
    .addr    (bc_addr),
    .wdata   (bc_wdata),
    .dq_i    (flash_dq_i),
    .busy    (bc_busy),
    .done    (bc_done),
    .rdata   (bc_rdata),
    .addr_o  (flash_addr),
    .dq_o    (flash_dq_o),
    .dq_oe   (flash_dq_oe),
    .ce_n    (flash_ce_n),
    .oe_n    (flash_oe_n),
    .we_n    (flash_we_n)
  );
endmodule : pfc_host

// ### bench/pfc_host_asserts.sv
module pfc_host_asserts
  import pfc_pkg::*;
#(
  parameter longint unsigned BP_TMO = 100,
  parameter longint unsigned EC_TMO = 100
) (
  input wire logic              sys_clk,
  input wire logic              srst,
  input wire logic              req_valid,
  input wire pfc_op_t           req_op,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic              req_ready,
  input wire logic              rsp_valid,
  input wire logic              id_mode,
  input wire logic              boot_hit,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic              flash_dq_oe,
  input wire logic              flash_ce_n,
  input wire logic              flash_oe_n,
  input wire logic              flash_we_n
);
  logic              busy_q;
  pfc_op_t           op_q;
  logic [31:0]       cnt_q;
  logic [2:0]        wr_q;
  logic [ADDR_W-1:0] pa_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      busy_q <= 1'b0;
    end else if (req_valid && req_ready) begin
      busy_q <= 1'b1;
      op_q   <= req_op;
      cnt_q  <= '0;
      wr_q   <= '0;
    end else if (rsp_valid) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q <= cnt_q + 1;
      if ($rose(flash_we_n) && wr_q != 3'h7) begin
        wr_q <= wr_q + 1;
        pa_q <= flash_addr;
      end
    end
  end
  sequence erase_fall;
    busy_q && op_q == PFC_OP_ERASE && $fell(flash_we_n);
  endsequence
  sequence erase_rise;
    busy_q && op_q == PFC_OP_ERASE && $rose(flash_we_n);
  endsequence
  erase_oe_a: assert property (erase_fall |-> flash_oe_n && !flash_ce_n)
    else $error("oe low at erase strobe");
  erase_rec_a: assert property (erase_rise |-> !flash_oe_n)
    else $error("oe high in erase recovery");
  strobe_excl_a: assert property (!(!flash_oe_n && !flash_we_n))
    else $error("oe and we low together");
  write_drive_a: assert property (!flash_we_n |-> flash_dq_oe)
    else $error("write strobe without data");
  poll_addr_a: assert property (busy_q && op_q == PFC_OP_PROGRAM && wr_q == 3'h4
    && !flash_ce_n |-> flash_addr == pa_q) else $error("poll address moved");
  prog_time_a: assert property (busy_q && op_q == PFC_OP_PROGRAM |-> cnt_q < BP_TMO + 200)
    else $error("program wait too long");
  erase_time_a: assert property (busy_q && op_q == PFC_OP_ERASE |-> cnt_q < EC_TMO + 200)
    else $error("erase wait too long");
  busy_block_a: assert property (busy_q && !rsp_valid |-> !req_ready)
    else $error("request taken while busy");
  rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
    else $error("response longer than a cycle");
  id_enter_a: assert property (rsp_valid && op_q == PFC_OP_ID_ENTER |-> ##[0:1] id_mode)
    else $error("id mode not set");
  id_exit_a: assert property (rsp_valid && op_q == PFC_OP_ID_EXIT |-> ##[0:1] !id_mode)
    else $error("id mode not left");
  boot_hit_a: assert property (boot_hit == (req_addr <= BOOT_HI))
    else $error("boot range flag wrong");
endmodule : pfc_host_asserts

bind pfc_host pfc_host_asserts #(.BP_TMO(BP_TMO), .EC_TMO(EC_TMO)) chk_u (
  .sys_clk(sys_clk), .srst(srst), .req_valid(req_valid), .req_op(req_op),
  .req_addr(req_addr), .req_ready(req_ready), .rsp_valid(rsp_valid), .id_mode(id_mode),
  .boot_hit(boot_hit), .flash_addr(flash_addr), .flash_dq_oe(flash_dq_oe),
  .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));

// ### bench/pfc_flash_model.sv
module pfc_flash_model
  import pfc_pkg::*;
#(
  parameter int         PRG_CYC  = 300,
  parameter int         ERS_CYC  = 500,
  parameter logic [7:0] MFR_CODE = 8'h5c, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h3e  // arbitrary value
) (
  input wire logic               sys_clk,
  input wire logic [ADDR_W-1:0]  flash_addr,
  input wire logic [DATA_W-1:0]  flash_dq_o,
  input wire logic               flash_ce_n,
  input wire logic               flash_oe_n,
  input wire logic               flash_we_n,
  output logic [DATA_W-1:0]      flash_dq_i
);
  logic [7:0] mem [0:255];
  logic [7:0] p1 = 8'h00, p2 = 8'h00, last = 8'h00;
  logic       prg = 1'b0, idm = 1'b0, lock_q = 1'b0, tog = 1'b0;
  int         cyc = 0, end_t = 0, slow = 0;
  logic              wr_act = 1'b0;
  logic [ADDR_W-1:0] wr_a = '0;
  logic [7:0]        wr_d = 8'h00;
  wire        busy = cyc < end_t;
  wire        idsel = idm && flash_addr[16:1] == 16'h0;
  wire [7:0]  val = busy ? {1'b0, tog, 6'h0} :
                    idsel ? (flash_addr[0] ? DEV_CODE : MFR_CODE) : mem[flash_addr[7:0]];
  // released bus shows the inverse so stale data never passes as a read
  assign flash_dq_i = (flash_ce_n || flash_oe_n) ? ~last : val;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'hff;
  always @(posedge sys_clk) cyc <= cyc + 1;
  always @(posedge flash_oe_n) begin
    last <= val;
    if (busy) tog <= ~tog;
  end
  // strobe sampled on the clock: ce and we rise together, so an edge
  // watcher would race; the write lands one clock after the strobe ends
  always @(posedge sys_clk) begin
    if (!flash_we_n && !flash_ce_n) begin
      wr_act <= 1'b1;
      wr_a   <= flash_addr;
      wr_d   <= flash_dq_o;
    end else if (wr_act && flash_we_n) begin
      wr_act <= 1'b0;
      if (!busy) begin
        if (prg) begin
          if (!(lock_q && wr_a <= BOOT_HI)) mem[wr_a[7:0]] <= wr_d;
          prg   <= 1'b0;
          end_t <= cyc + (slow > 0 ? slow : PRG_CYC);
        end else if (p2 == 8'haa && p1 == 8'h55 && wr_a[14:0] == 15'h5555) begin
          case (wr_d)
            8'ha0: prg <= 1'b1;
            8'h90: idm <= 1'b1;
            8'hf0: idm <= 1'b0;
            8'h40: lock_q <= 1'b1;
            8'h10: begin
              if (!lock_q) for (int i = 0; i < 256; i++) mem[i] <= 8'hff;
              end_t <= cyc + ERS_CYC;
            end
            default: ;
          endcase
        end
        p2 <= p1;
        p1 <= wr_d;
      end
    end
  end
endmodule : pfc_flash_model

// ### bench/tb_pfc_host.sv
module tb_pfc_host
  import pfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam longint unsigned BP  = BP_CYC;
  localparam logic [7:0]      MFR = 8'h5c; // arbitrary value
  localparam logic [7:0]      DEV = 8'h3e; // arbitrary value
  logic sys_clk = 0, srst = 1, req_valid = 0, req_ready, rsp_valid, rsp_timeout;
  logic id_mode, boot_hit, dq_oe, ce_n, oe_n, we_n;
  pfc_op_t req_op = PFC_OP_READ;
  logic [ADDR_W-1:0] req_addr = '0, flash_addr;
  logic [7:0] req_data = '0, rsp_data, dq_i, dq_o, got;
  logic tmo;
  int n_fail = 0, checks_done = 0;
  pfc_host #(.BP_TMO(BP), .EC_TMO(2000)) dut_u (.sys_clk(sys_clk), .srst(srst),
    .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_timeout(rsp_timeout), .id_mode(id_mode), .boot_hit(boot_hit),
    .flash_addr(flash_addr), .flash_dq_i(dq_i), .flash_dq_o(dq_o), .flash_dq_oe(dq_oe),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n));
  pfc_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) flash_u (.sys_clk(sys_clk),
    .flash_addr(flash_addr), .flash_dq_o(dq_o), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .flash_dq_i(dq_i));
  initial forever #4 sys_clk = ~sys_clk;
  task chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, g, e);
    end
  endtask : chk
  task do_op(input pfc_op_t op, input logic [16:0] a, input logic [7:0] d);
    int i;
    @(posedge sys_clk);
    req_op <= op;
    req_addr <= a;
    req_data <= d;
    req_valid <= 1'b1;
    i = 0;
    @(negedge sys_clk);
    while (req_ready !== 1'b1 && i < 1000) begin
      @(negedge sys_clk);
      i++;
    end
    chk({7'h0, req_ready}, 8'h01);
    @(posedge sys_clk);
    req_valid <= 1'b0;
    i = 0;
    @(negedge sys_clk);
    while (rsp_valid !== 1'b1 && i < 30000) begin
      @(negedge sys_clk);
      i++;
    end
    chk({7'h0, rsp_valid}, 8'h01);
    got = rsp_data;
    tmo = rsp_timeout;
  endtask : do_op
  task t_prog;
    do_op(PFC_OP_PROGRAM, 17'h00123, 8'h5a);
    chk({7'h0, tmo}, 8'h00);
    do_op(PFC_OP_READ, 17'h00123, 8'h00);
    chk(got, 8'h5a);
  endtask : t_prog
  task t_boot;
    @(posedge sys_clk);
    req_addr <= 17'h01fff;
    @(negedge sys_clk);
    chk({7'h0, boot_hit}, 8'h01);
    @(posedge sys_clk);
    req_addr <= 17'h02000;
    @(negedge sys_clk);
    chk({7'h0, boot_hit}, 8'h00);
  endtask : t_boot
  task t_id;
    do_op(PFC_OP_ID_ENTER, 17'h0, 8'h00);
    @(negedge sys_clk);
    chk({7'h0, id_mode}, 8'h01);
    do_op(PFC_OP_READ, ID_MFR_ADDR, 8'h00);
    chk(got, MFR);
    do_op(PFC_OP_READ, ID_DEV_ADDR, 8'h00);
    chk(got, DEV);
    do_op(PFC_OP_ID_EXIT, 17'h0, 8'h00);
    @(negedge sys_clk);
    chk({7'h0, id_mode}, 8'h00);
    do_op(PFC_OP_READ, 17'h00123, 8'h00);
    chk(got, 8'h5a);
  endtask : t_id
  task t_raw;
    // plain writes build the id entry sequence by hand
    do_op(PFC_OP_RAW, 17'h05555, 8'haa);
    do_op(PFC_OP_RAW, 17'h02aaa, 8'h55);
    do_op(PFC_OP_RAW, 17'h05555, 8'h90);
    do_op(PFC_OP_READ, ID_DEV_ADDR, 8'h00);
    chk(got, DEV);
    do_op(PFC_OP_ID_EXIT, 17'h0, 8'h00);
    do_op(PFC_OP_READ, 17'h00123, 8'h00);
    chk(got, 8'h5a);
  endtask : t_raw
  task t_erase;
    do_op(PFC_OP_ERASE, 17'h0, 8'h00);
    chk({7'h0, tmo}, 8'h00);
    do_op(PFC_OP_READ, 17'h00123, 8'h00);
    chk(got, 8'hff);
  endtask : t_erase
  task t_lock;
    do_op(PFC_OP_PROGRAM, 17'h00010, 8'h33);
    do_op(PFC_OP_LOCKOUT, 17'h0, 8'h00);
    chk({7'h0, flash_u.lock_q}, 8'h01);
    do_op(PFC_OP_ERASE, 17'h0, 8'h00);
    do_op(PFC_OP_READ, 17'h00010, 8'h00);
    chk(got, 8'h33);
  endtask : t_lock
  task t_tmo;
    // device stalls past the limit; controller must give up, not hang
    flash_u.slow = 2 * BP;
    do_op(PFC_OP_PROGRAM, 17'h00020, 8'h11);
    chk({7'h0, tmo}, 8'h01);
    flash_u.slow = 0;
    repeat (2 * BP) @(posedge sys_clk);
  endtask : t_tmo
  task close_out;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_fail++;
    close_out;
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    t_prog;
    t_boot;
    t_id;
    t_raw;
    t_erase;
    t_lock;
    t_tmo;
    close_out;
  end
endmodule : tb_pfc_host
